// ==== cdm_macrocell.sv ====
`timescale 1ns/1ps
`default_nettype none

module cdm_macrocell
    import cdm_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [3:0] matrix_in,
    input wire logic fast_oscillator,
    input wire logic middle_oscillator,
    input wire logic slow_oscillator,
    input wire logic chained_counter_done,
    output logic macro_out,
    output logic count_done
);

    // --------------------------------------------------------------------
    // register file
    // --------------------------------------------------------------------
    logic [DATA_W-1:0] macrocell_topology_byte_ff;
    logic [DATA_W-1:0] counter_mode_clock_byte_ff;
    logic [DATA_W-1:0] counter_options_byte_ff;
    logic [CNT_W-1:0] counter_data_ff;
    logic [15:0] table_truth_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic options_written_ff;
    cdm_cfg_type cfg;
    logic [CNT_W-1:0] cnt_ff;
    cdm_state_type state_ff;
    logic out_ff;
    logic done_ff;
    logic macro_out_ff;
    logic delay_input;

    wire wr_topo = reg_wr && (reg_addr == OFS_TOPOLOGY);
    wire wr_modeclk = reg_wr && (reg_addr == OFS_MODE_CLOCK);
    wire wr_opts = reg_wr && (reg_addr == OFS_OPTIONS);
    wire wr_data_lo = reg_wr && (reg_addr == OFS_DATA_LO);
    wire wr_data_hi = reg_wr && (reg_addr == OFS_DATA_HI);
    wire wr_tab_lo = reg_wr && (reg_addr == OFS_TABLE_LO);
    wire wr_tab_hi = reg_wr && (reg_addr == OFS_TABLE_HI);

    // config is meant to be written once after power-up, before use
    assign cfg = cdm_cfg_type'({counter_options_byte_ff, counter_mode_clock_byte_ff, macrocell_topology_byte_ff});

    wire [DATA_W-1:0] status_byte = {5'h00, state_ff == CDM_RUN, delay_input, macro_out_ff};
    wire [DATA_W-1:0] rd_mux =
        (reg_addr == OFS_TOPOLOGY) ? macrocell_topology_byte_ff :
        (reg_addr == OFS_MODE_CLOCK) ? counter_mode_clock_byte_ff :
        (reg_addr == OFS_OPTIONS) ? counter_options_byte_ff :
        (reg_addr == OFS_DATA_LO) ? counter_data_ff[7:0] :
        (reg_addr == OFS_DATA_HI) ? counter_data_ff[15:8] :
        (reg_addr == OFS_TABLE_LO) ? table_truth_ff[7:0] :
        (reg_addr == OFS_TABLE_HI) ? table_truth_ff[15:8] :
        (reg_addr == OFS_COUNT_LO) ? cnt_ff[7:0] :
        (reg_addr == OFS_COUNT_HI) ? cnt_ff[15:8] :
        (reg_addr == OFS_STATUS) ? status_byte : RST_BYTE;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            macrocell_topology_byte_ff <= RST_BYTE;
            counter_mode_clock_byte_ff <= RST_BYTE;
            counter_options_byte_ff <= RST_BYTE;
            counter_data_ff <= '0;
            table_truth_ff <= '0;
            rdata_ff <= RST_BYTE;
            options_written_ff <= 1'b0;
        end else begin
            if (wr_topo) macrocell_topology_byte_ff <= reg_wdata;
            if (wr_modeclk) counter_mode_clock_byte_ff <= reg_wdata;
            if (wr_opts) counter_options_byte_ff <= reg_wdata;
            if (wr_data_lo) counter_data_ff[7:0] <= reg_wdata;
            if (wr_data_hi) counter_data_ff[15:8] <= reg_wdata;
            if (wr_tab_lo) table_truth_ff[7:0] <= reg_wdata;
            if (wr_tab_hi) table_truth_ff[15:8] <= reg_wdata;
            rdata_ff <= reg_rd ? rd_mux : RST_BYTE;
            options_written_ff <= wr_opts;
        end
    end

    // --------------------------------------------------------------------
    // oscillator sampling and dividers
    // --------------------------------------------------------------------
    logic [1:0] fast_sync_ff, mid_sync_ff, slow_sync_ff;
    logic fast_prev_ff, mid_prev_ff, slow_prev_ff, ext_prev_ff;
    logic [FAST_DIV4_W-1:0] fast_div_ff;
    logic [DIV512_W-1:0] mid_div_ff;
    logic [DIV262144_W-1:0] slow_div_ff;
    logic external_count_clock;

    wire fast_tick = fast_sync_ff[1] && !fast_prev_ff;
    wire mid_tick = mid_sync_ff[1] && !mid_prev_ff;
    wire slow_tick = slow_sync_ff[1] && !slow_prev_ff;
    wire ext_tick = external_count_clock && !ext_prev_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fast_sync_ff <= 2'h0;
            mid_sync_ff <= 2'h0;
            slow_sync_ff <= 2'h0;
            fast_prev_ff <= 1'b0;
            mid_prev_ff <= 1'b0;
            slow_prev_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
            fast_div_ff <= '0;
            mid_div_ff <= '0;
            slow_div_ff <= '0;
        end else begin
            fast_sync_ff <= {fast_sync_ff[0], fast_oscillator};
            mid_sync_ff <= {mid_sync_ff[0], middle_oscillator};
            slow_sync_ff <= {slow_sync_ff[0], slow_oscillator};
            fast_prev_ff <= fast_sync_ff[1];
            mid_prev_ff <= mid_sync_ff[1];
            slow_prev_ff <= slow_sync_ff[1];
            ext_prev_ff <= external_count_clock;
            if (fast_tick) fast_div_ff <= fast_div_ff + 1'b1;
            if (mid_tick) mid_div_ff <= mid_div_ff + 1'b1;
            if (slow_tick) slow_div_ff <= slow_div_ff + 1'b1;
        end
    end

    logic [15:0] tick_vec;
    assign tick_vec[0] = fast_tick;
    assign tick_vec[1] = fast_tick && (&fast_div_ff);
    assign tick_vec[2] = mid_tick;
    assign tick_vec[3] = mid_tick && (&mid_div_ff[DIV8_W-1:0]);
    assign tick_vec[4] = mid_tick && (&mid_div_ff[DIV64_W-1:0]);
    assign tick_vec[5] = mid_tick && (&mid_div_ff);
    assign tick_vec[6] = slow_tick;
    assign tick_vec[7] = slow_tick && (&slow_div_ff[DIV8_W-1:0]);
    assign tick_vec[8] = slow_tick && (&slow_div_ff[DIV64_W-1:0]);
    assign tick_vec[9] = slow_tick && (&slow_div_ff[DIV512_W-1:0]);
    assign tick_vec[10] = slow_tick && (&slow_div_ff[DIV4096_W-1:0]);
    assign tick_vec[11] = slow_tick && (&slow_div_ff[DIV32768_W-1:0]);
    assign tick_vec[12] = slow_tick && (&slow_div_ff);
    assign tick_vec[13] = chained_counter_done;
    assign tick_vec[14] = ext_tick;
    assign tick_vec[15] = 1'b0;
    wire src_tick = tick_vec[cfg.clk_sel];

    // --------------------------------------------------------------------
    // topology routing
    // --------------------------------------------------------------------
    wire [1:0] chain = cfg.chain_kind;
    wire [1:0] idx = IDX_TOP - cfg.chain_pos;
    wire [1:0] ext_pos = {cfg.ext_pos_hi, cfg.ext_pos_lo};
    logic [3:0] logic_in;
    logic delay_output;
    logic flop_output_ff;
    logic flop_clk_prev_ff;
    wire table_output = table_truth_ff[logic_in];
    wire displaced_tie = cfg.is_flop; // table input low, flop set/reset high
    // solo topology, and chained topologies with ext_pos B or C, lend a matrix input to the counter clock
    wire chained = (chain == CHAIN_TO_LOGIC) || (chain == CHAIN_FROM_LOGIC);

    always_comb begin
        logic_in = matrix_in;
        if (chain == CHAIN_TO_LOGIC) logic_in[idx] = delay_output;
        if (chained && ext_pos == EXT_POS_B) logic_in[2] = displaced_tie;
        if (chained && ext_pos == EXT_POS_C) logic_in[1] = displaced_tie;
    end

    always_comb begin
        case (chain)
            CHAIN_NONE: delay_input = 1'b0;
            CHAIN_SOLO: delay_input = matrix_in[0];
            CHAIN_TO_LOGIC: delay_input = matrix_in[idx];
            CHAIN_FROM_LOGIC: delay_input = cfg.is_flop ? flop_output_ff : table_output;
            default: delay_input = 1'b0;
        endcase
    end

    assign external_count_clock = (chain == CHAIN_SOLO) ? matrix_in[1] :
        (chained && ext_pos == EXT_POS_B) ? matrix_in[2] :
        (chained && ext_pos == EXT_POS_C) ? matrix_in[1] : 1'b0;

    // flop: in3 data, in2 set low, in1 reset low, in0 clock; reset beats set
    wire flop_rise = logic_in[0] && !flop_clk_prev_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flop_output_ff <= 1'b0;
            flop_clk_prev_ff <= 1'b0;
        end else begin
            flop_clk_prev_ff <= logic_in[0];
            if (!logic_in[1]) flop_output_ff <= 1'b0;
            else if (!logic_in[2]) flop_output_ff <= 1'b1;
            else if (flop_rise) flop_output_ff <= logic_in[3];
        end
    end

    // --------------------------------------------------------------------
    // direction / hold synchronisers (standalone only)
    // --------------------------------------------------------------------
    logic [1:0] dir_sync_ff, hold_sync_ff;
    wire dir_raw = (chain == CHAIN_SOLO) && matrix_in[3];
    wire hold_raw = (chain == CHAIN_SOLO) && matrix_in[2];
    wire count_up = cfg.dir_sync ? dir_sync_ff[1] : dir_raw;
    wire count_hold = cfg.hold_sync ? hold_sync_ff[1] : hold_raw;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dir_sync_ff <= 2'h0;
            hold_sync_ff <= 2'h0;
        end else begin
            dir_sync_ff <= {dir_sync_ff[0], dir_raw};
            hold_sync_ff <= {hold_sync_ff[0], hold_raw};
        end
    end

    // --------------------------------------------------------------------
    // delay / counter core
    // --------------------------------------------------------------------
    logic din_prev_ff;
    logic target_ff;
    wire din_rise = delay_input && !din_prev_ff;
    wire din_fall = !delay_input && din_prev_ff;
    logic qual;
    always_comb begin
        case (cfg.edge_sel)
            EDGE_BOTH: qual = din_rise || din_fall;
            EDGE_FALL: qual = din_fall;
            EDGE_RISE: qual = din_rise;
            EDGE_LEVEL: qual = (cfg.mode == MODE_COUNT) && delay_input; // only valid in counter mode
            default: qual = 1'b0;
        endcase
    end

    wire running = (state_ff == CDM_RUN);
    wire expired = running && src_tick && (cnt_ff == '0);
    wire count_end = count_up ? (cnt_ff == counter_data_ff) : (cnt_ff == '0);
    wire [CNT_W-1:0] reset_value = cfg.load_data_on_reset ? counter_data_ff : '0;
    logic [CNT_W-1:0] nxt_cnt;
    cdm_state_type nxt_state;
    logic nxt_out, nxt_target, nxt_done;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_state = state_ff;
        nxt_out = out_ff;
        nxt_target = target_ff;
        nxt_done = 1'b0;
        case (cfg.mode)
            MODE_DELAY: begin
                if (qual) begin
                    nxt_out = cfg.edge_detect_option ? 1'b1 : out_ff; // pulse per edge
                    nxt_target = cfg.edge_detect_option ? 1'b0 : delay_input;
                    nxt_cnt = counter_data_ff;
                    nxt_state = CDM_RUN;
                end else if (!cfg.edge_detect_option && (din_rise || din_fall)) begin
                    // unsensed edge passes straight through and aborts a pending delay
                    nxt_out = delay_input;
                    nxt_state = CDM_IDLE;
                end else if (expired) begin
                    nxt_out = target_ff;
                    nxt_state = CDM_IDLE;
                    nxt_done = 1'b1;
                end else if (running && src_tick) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            MODE_ONESHOT: begin
                if (qual && !running) begin
                    nxt_out = 1'b1;
                    nxt_cnt = counter_data_ff;
                    nxt_state = CDM_RUN;
                end else if (expired) begin
                    nxt_out = 1'b0;
                    nxt_state = CDM_IDLE;
                    nxt_done = 1'b1;
                end else if (running && src_tick) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            MODE_FREQ: begin
                if (qual) begin
                    // high while edges come faster than the programmed period
                    nxt_out = running;
                    nxt_cnt = counter_data_ff;
                    nxt_state = CDM_RUN;
                end else if (expired) begin
                    nxt_out = 1'b0;
                    nxt_state = CDM_IDLE;
                    nxt_done = 1'b1;
                end else if (running && src_tick) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            MODE_COUNT: begin
                nxt_state = CDM_RUN;
                if (qual) begin
                    nxt_cnt = reset_value;
                    nxt_out = 1'b0;
                end else if (src_tick && !count_hold) begin
                    nxt_out = count_end;
                    nxt_done = count_end;
                    if (count_end) nxt_cnt = count_up ? '0 : counter_data_ff;
                    else nxt_cnt = count_up ? cnt_ff + 1'b1 : cnt_ff - 1'b1;
                end
            end
            default: ;
        endcase
        if (options_written_ff && cfg.init_sel != INIT_BYPASS) begin
            nxt_out = (cfg.init_sel != INIT_ZERO);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_ff <= '0;
            state_ff <= CDM_IDLE;
            out_ff <= 1'b0;
            target_ff <= 1'b0;
            done_ff <= 1'b0;
            din_prev_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            state_ff <= nxt_state;
            out_ff <= nxt_out;
            target_ff <= nxt_target;
            done_ff <= nxt_done;
            din_prev_ff <= delay_input;
        end
    end

    // --------------------------------------------------------------------
    // output path
    // --------------------------------------------------------------------
    wire ws_active = cfg.wake_sleep_mode && (cfg.mode == MODE_COUNT);
    wire ws_power_down = ws_active && !out_ff && (cnt_ff != '0);
    assign delay_output = ws_power_down ? cfg.wake_sleep_level : (out_ff ^ cfg.out_invert);
    wire nxt_macro_out = (chain == CHAIN_SOLO) ? delay_output :
        (cfg.is_flop ? flop_output_ff : table_output);

    always_ff @(posedge clk) begin
        if (sys_rst) macro_out_ff <= 1'b0;
        else macro_out_ff <= nxt_macro_out;
    end

    assign macro_out = macro_out_ff;
    assign count_done = done_ff;
    assign reg_rdata = rdata_ff;

    // --------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    reg_write_a: assert property (wr_modeclk |=> counter_mode_clock_byte_ff == $past(reg_wdata))
        else $error("mode/clock byte not stored");
    read_data_a: assert property (reg_rd && reg_addr == OFS_TOPOLOGY && !reg_wr
        |=> reg_rdata == macrocell_topology_byte_ff)
        else $error("topology byte read back wrong");
    table_only_a: assert property (chain == CHAIN_NONE |-> !delay_input)
        else $error("delay input not low in plain topology");
    flop_reset_a: assert property (cfg.is_flop && chain == CHAIN_NONE && !matrix_in[1]
        |=> !flop_output_ff)
        else $error("flop reset not honoured");
    dir_sync_a: assert property (cfg.dir_sync && chain == CHAIN_SOLO && $stable(cfg)
        ##1 $stable(cfg) ##1 $stable(cfg) |-> count_up == $past(dir_raw, 2))
        else $error("direction not two flops late");
    hold_sync_a: assert property (cfg.hold_sync && chain == CHAIN_SOLO && $stable(cfg)
        ##1 $stable(cfg) ##1 $stable(cfg) |-> count_hold == $past(hold_raw, 2))
        else $error("hold not two flops late");
    count_reset_a: assert property (cfg.mode == MODE_COUNT && qual && !options_written_ff
        |=> cnt_ff == $past(reset_value) && !out_ff)
        else $error("counter reset value wrong");
    oneshot_start_a: assert property (cfg.mode == MODE_ONESHOT && qual && !running && !options_written_ff
        |=> out_ff && running && cnt_ff == counter_data_ff)
        else $error("one-shot did not start");
    polarity_a: assert property (chain == CHAIN_SOLO && !ws_active && $stable(cfg)
        |=> macro_out == $past(out_ff ^ cfg.out_invert))
        else $error("output polarity wrong");
    wake_level_a: assert property (chain == CHAIN_SOLO && ws_power_down
        |=> macro_out == $past(cfg.wake_sleep_level))
        else $error("wake-sleep level not presented");
    clock_sel_a: assert property ((&cfg.clk_sel) && cfg.mode == MODE_COUNT && !qual
        |=> cnt_ff == $past(cnt_ff))
        else $error("unused clock source moved the count");
    done_pulse_a: assert property (count_done |=> !count_done)
        else $error("done longer than one cycle");

    oneshot_c: cover property (cfg.mode == MODE_ONESHOT && expired);
    counter_end_c: cover property (cfg.mode == MODE_COUNT && count_done);
    delay_end_c: cover property (cfg.mode == MODE_DELAY && !cfg.edge_detect_option && expired);
    freq_hit_c: cover property (cfg.mode == MODE_FREQ && qual && running);

endmodule // cdm_macrocell

`default_nettype wire

// ==== cdm_matrix_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module cdm_matrix_model (
    input wire logic clk,
    input wire logic ext_run,
    output logic external_count_clock,
    output logic fast_oscillator,
    output logic middle_oscillator,
    output logic slow_oscillator
);
    logic [1:0] div_ff = 2'h0;
    initial begin
        external_count_clock = 1'b0;
        fast_oscillator = 1'b0;
        middle_oscillator = 1'b0;
        slow_oscillator = 1'b0;
    end
    // free-running, unrelated in phase to clk
    always #23 fast_oscillator = ~fast_oscillator;
    always #245 middle_oscillator = ~middle_oscillator;
    always #2450 slow_oscillator = ~slow_oscillator;
    // external count clock stands still between bursts
    always @(posedge clk) begin
        div_ff <= ext_run ? div_ff + 2'h1 : 2'h0;
        external_count_clock <= ext_run & div_ff[1];
    end
endmodule // cdm_matrix_model

`default_nettype wire

// ==== cdm_pkg.sv ====
package cdm_pkg;

    // --------------------------------------------------------------------
    // register map
    // --------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_TOPOLOGY = 8'h80;
    localparam logic [ADDR_W-1:0] OFS_MODE_CLOCK = 8'h81;
    localparam logic [ADDR_W-1:0] OFS_OPTIONS = 8'h82;
    localparam logic [ADDR_W-1:0] OFS_DATA_LO = 8'h90;
    localparam logic [ADDR_W-1:0] OFS_DATA_HI = 8'h91;
    localparam logic [ADDR_W-1:0] OFS_TABLE_LO = 8'h92;
    localparam logic [ADDR_W-1:0] OFS_TABLE_HI = 8'h93;
    localparam logic [ADDR_W-1:0] OFS_COUNT_LO = 8'h94;
    localparam logic [ADDR_W-1:0] OFS_COUNT_HI = 8'h95;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h96;
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

    // --------------------------------------------------------------------
    // field encodings
    // --------------------------------------------------------------------
    localparam logic [1:0] MODE_DELAY = 2'h0;
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_FREQ = 2'h2;
    localparam logic [1:0] MODE_COUNT = 2'h3;
    localparam logic [1:0] EDGE_BOTH = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_LEVEL = 2'h3;
    localparam logic [1:0] INIT_BYPASS = 2'h0;
    localparam logic [1:0] INIT_ZERO = 2'h1;
    localparam logic [1:0] CHAIN_NONE = 2'h0;
    localparam logic [1:0] CHAIN_SOLO = 2'h1;
    localparam logic [1:0] CHAIN_TO_LOGIC = 2'h2;
    localparam logic [1:0] CHAIN_FROM_LOGIC = 2'h3;
    localparam logic [1:0] EXT_POS_B = 2'h1;
    localparam logic [1:0] EXT_POS_C = 2'h2;
    localparam logic [1:0] IDX_TOP = 2'h3;

    // divider widths: divide ratio is two to this power
    localparam int FAST_DIV4_W = 2;
    localparam int DIV8_W = 3;
    localparam int DIV64_W = 6;
    localparam int DIV512_W = 9;
    localparam int DIV4096_W = 12;
    localparam int DIV32768_W = 15;
    localparam int DIV262144_W = 18;

    // --------------------------------------------------------------------
    // configuration image, options byte on top, topology byte at bottom
    // --------------------------------------------------------------------
    typedef struct packed {
        logic out_invert;
        logic wake_sleep_mode;
        logic wake_sleep_level;
        logic [1:0] init_sel;
        logic hold_sync;
        logic dir_sync;
        logic edge_detect_option;
        logic load_data_on_reset;
        logic [3:0] clk_sel;
        logic [1:0] edge_sel;
        logic [1:0] mode;
        logic ext_pos_hi;
        logic ext_pos_lo;
        logic is_flop;
        logic [1:0] chain_pos;
        logic [1:0] chain_kind;
    } cdm_cfg_type;

    typedef enum logic [0:0] {
        CDM_IDLE,
        CDM_RUN
    } cdm_state_type;

endpackage

// ==== test_cdm_macrocell.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_cdm_macrocell
    import cdm_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_ff = 1'b0;
    logic ext_run = 1'b0;
    logic [3:0] mtx = 4'h0;
    logic [7:0] reg_rdata, exp_v;
    logic external_count_clock, fosc, mosc, sosc, macro_out, count_done;
    logic [7:0] exp_q[$];
    logic [31:0] rng = 32'hd717;
    logic [15:0] tbl;
    logic [3:0] fl_m[7] = '{4'h4, 4'he, 4'hf, 4'hd, 4'hb, 4'h3, 4'h1};
    logic [6:0] fl_e = 7'h34;
    int fails = 0;
    int comparisons = 0;
    int dones = 0;

    always #10 clk = ~clk;

    cdm_matrix_model peer (.clk(clk), .ext_run(ext_run), .external_count_clock(external_count_clock),
        .fast_oscillator(fosc), .middle_oscillator(mosc), .slow_oscillator(sosc));

    cdm_macrocell dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .matrix_in({mtx[3:2], mtx[1] | external_count_clock, mtx[0]}), .fast_oscillator(fosc),
        .middle_oscillator(mosc), .slow_oscillator(sosc), .chained_counter_done(1'b0),
        .macro_out(macro_out), .count_done(count_done));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic kick;
        repeat (4) @(posedge clk);
        dones = 0;
        mtx <= 4'h1;
        repeat (3) @(posedge clk);
    endtask

    // ten rising external clock edges, then the clock stands still
    task automatic burst;
        ext_run <= 1'b1;
        repeat (40) @(posedge clk);
        ext_run <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic chk_dones(input int e);
        comparisons++;
        if (dones != e) begin
            fails++;
            $display("[ERR] count_done pulses exp %0d got %0d", e, dones);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        rd_ff <= reg_rd;
        if (count_done === 1'b1) dones++;
        if (rd_ff) begin
            exp_v = exp_q.pop_front();
            comparisons++;
            if (reg_rdata !== exp_v) begin
                fails++;
                $display("[ERR] reg_rdata exp %h got %h", exp_v, reg_rdata);
            end
        end
    end

    initial begin
        #200_000;
        fails++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            rd(OFS_TOPOLOGY + i[7:0], RST_BYTE);
            rng = xs(rng);
            wr(OFS_TOPOLOGY + i[7:0], rng[7:0]);
            rd(OFS_TOPOLOGY + i[7:0], rng[7:0]);
        end
        wr(8'h7f, 8'hff);
        rd(8'h7f, 8'h00);
        // second reset puts the cell back to the table topology
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        $display("test registers done");
        rng = xs(rng);
        tbl = rng[15:0];
        wr(OFS_TABLE_LO, tbl[7:0]);
        wr(OFS_TABLE_HI, tbl[15:8]);
        for (int i = 0; i < 16; i++) begin
            mtx <= i[3:0];
            repeat (3) @(posedge clk);
            rd(OFS_STATUS, {7'h0, tbl[i]});
        end
        $display("test table done");
        wr(OFS_TOPOLOGY, 8'h10);
        for (int i = 0; i < 7; i++) begin
            mtx <= fl_m[i];
            repeat (3) @(posedge clk);
            rd(OFS_STATUS, {7'h0, fl_e[i]});
        end
        $display("test flop done");
        for (int inv = 0; inv < 2; inv++) begin
            mtx <= 4'h0;
            wr(OFS_TOPOLOGY, 8'h81);
            wr(OFS_MODE_CLOCK, 8'h74);
            wr(OFS_DATA_LO, 8'h02);
            wr(OFS_OPTIONS, {inv[0], 7'h0});
            kick();
            rd(OFS_STATUS, {5'h0, 2'h3, ~inv[0]});
            burst();
            rd(OFS_STATUS, {6'h0, 1'b1, inv[0]});
            chk_dones(1);
        end
        $display("test one-shot done");
        // counter mode, load data on rising edge, synced inputs, wake-sleep level high
        mtx <= 4'h0;
        wr(OFS_MODE_CLOCK, 8'hf5);
        wr(OFS_DATA_LO, 8'h03);
        wr(OFS_OPTIONS, 8'h66);
        kick();
        rd(OFS_COUNT_LO, 8'h03);
        burst();
        rd(OFS_COUNT_LO, 8'h01);
        rd(OFS_STATUS, 8'h07);
        chk_dones(2);
        $display("test counter done");
        // delay mode with the edge-detect option: a pulse per sensed edge
        mtx <= 4'h0;
        wr(OFS_TOPOLOGY, 8'h01);
        wr(OFS_MODE_CLOCK, 8'h70);
        wr(OFS_OPTIONS, 8'h01);
        kick();
        rd(OFS_STATUS, 8'h07);
        burst();
        rd(OFS_STATUS, 8'h02);
        chk_dones(1);
        $display("test edge detect done");
        summarize();
    end
endmodule // test_cdm_macrocell

`default_nettype wire
